// *** common/pieb_pkg.sv ***
// package: register map, field positions and reset values of the enable bank
package pieb_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [5:0]  OFS_GROUP2    = 6'h00;
    localparam logic [5:0]  OFS_GROUP3    = 6'h04;
    localparam logic [5:0]  OFS_GROUP4    = 6'h08;
    localparam logic [5:0]  OFS_PEND      = 6'h0C;
    localparam logic [5:0]  OFS_SEEN      = 6'h10;
    localparam logic [5:0]  OFS_SEEN_CLR  = 6'h14;
    localparam logic [5:0]  OFS_SEEN_EN   = 6'h18;
    // writable masks of the three enable registers
    localparam logic [15:0] MASK_GROUP2   = 16'h601F;
    localparam logic [15:0] MASK_GROUP3   = 16'h7800;
    localparam logic [15:0] MASK_GROUP4   = 16'hC07E;
    // can-related bits per register
    localparam logic [15:0] CAN_GROUP2    = 16'h000C;
    localparam logic [15:0] CAN_GROUP4    = 16'h0040;
    // dac-related bits
    localparam logic [15:0] DAC_GROUP4    = 16'hC000;
    // reset value of every enable register
    localparam logic [15:0] ENABLE_RESET  = 16'h0000;
    // axi response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // number of request lines (3 x 16 bit slots)
    localparam int          NUM_REQ       = 48;
endpackage

// *** design/pieb_gate.sv ***
// per-line request gate with an assertion tying output to enable and flag
`timescale 1ns/1ps
module pieb_gate
    import pieb_pkg::*;
#(
    parameter int WIDTH = 48
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] flag_i,
    input  wire logic [WIDTH-1:0] enable_i,
    output logic      [WIDTH-1:0] req_o
);
    logic [WIDTH-1:0] next_req;   // masked request, next value
    logic [WIDTH-1:0] req;        // registered masked request

    // one and gate per line; flag itself is never touched
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_gate
            always_comb begin
                next_req[g] = flag_i[g] & enable_i[g];
            end
        end
    endgenerate

    // registered so the output comes from a flop
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    assign req_o = req;

    chk_gate_follows: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        req_o == ($past(flag_i) & $past(enable_i)))
        else $error("masked request does not follow flag and enable");
endmodule

// *** design/pieb_top.sv ***
// top: axi4-lite enable bank gating peripheral requests
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module pieb_top
    import pieb_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1,   // device variant has the can module
    parameter bit HAS_DAC = 1'b1    // device variant has the audio dac
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // axi4-lite slave
    input  wire logic [5:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [5:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // peripheral request flags, same bit layout as the enables
    input  wire logic [15:0] flag_group2_i,
    input  wire logic [15:0] flag_group3_i,
    input  wire logic [15:0] flag_group4_i,
    // masked requests toward priority logic
    output logic      [15:0] req_group2_o,
    output logic      [15:0] req_group3_o,
    output logic      [15:0] req_group4_o,
    // summary interrupt
    output logic             irq_o
);
    // variant masks: absent modules lose their enable bits
    localparam logic [15:0] LIVE2 = MASK_GROUP2 &
        ~(HAS_CAN ? 16'h0000 : CAN_GROUP2);
    localparam logic [15:0] LIVE3 = MASK_GROUP3;
    localparam logic [15:0] LIVE4 = MASK_GROUP4 &
        ~(HAS_CAN ? 16'h0000 : CAN_GROUP4) &
        ~(HAS_DAC ? 16'h0000 : DAC_GROUP4);

    // enable registers
    logic [15:0] en2, en3, en4;                 // stored enables
    logic [15:0] next_en2, next_en3, next_en4;
    // sticky status of masked requests, plus its enable
    logic [2:0]  seen, next_seen;               // per group activity
    logic [2:0]  seen_en, next_seen_en;
    logic        irq, next_irq;
    // axi channel state
    logic        aw_hold, next_aw_hold;         // address taken
    logic        w_hold, next_w_hold;           // data taken
    logic [5:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;
    // ready flags kept in flops so bus outputs leave a register
    logic        aw_rdy, next_aw_rdy;           // address slot free
    logic        w_rdy, next_w_rdy;             // data slot free
    logic        ar_rdy, next_ar_rdy;           // read slot free
    // gate outputs
    logic [NUM_REQ-1:0] req_all;

    logic aw_take, w_take, do_write, ar_take;

    // only one write in flight: hold each channel until the pair completes
    assign aw_take  = s_axi_awvalid_i && !aw_hold && !bvalid;
    assign w_take   = s_axi_wvalid_i && !w_hold && !bvalid;
    assign ar_take  = s_axi_arvalid_i && !rvalid;

    // write pair present, either order
    always_comb begin
        do_write = (aw_hold || aw_take) && (w_hold || w_take);
    end

    // strobe-aware merge of a 16 bit register from the low two lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb,
        input logic [15:0] live
    );
        logic [15:0] v;
        v = old;
        if (strb[0]) v[7:0]  = data[7:0];
        if (strb[1]) v[15:8] = data[15:8];
        return v & live;  // unimplemented bits never store
    endfunction

    // write path, register update and bus write answer
    always_comb begin
        logic [5:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        a = aw_take ? s_axi_awaddr_i : aw_addr;
        d = w_take  ? s_axi_wdata_i  : w_data;
        s = w_take  ? s_axi_wstrb_i  : w_strb;
        next_en2     = en2;
        next_en3     = en3;
        next_en4     = en4;
        next_seen_en = seen_en;
        next_aw_hold = aw_hold || aw_take;
        next_w_hold  = w_hold || w_take;
        next_aw_addr = aw_take ? s_axi_awaddr_i : aw_addr;
        next_w_data  = w_take ? s_axi_wdata_i : w_data;
        next_w_strb  = w_take ? s_axi_wstrb_i : w_strb;
        next_bvalid  = bvalid && !s_axi_bready_i;
        next_bresp   = bresp;
        next_seen    = seen | {|req_all[47:32], |req_all[31:16],
                               |req_all[15:0]};
        if (do_write) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (a & 6'h3C)
                OFS_GROUP2:   next_en2 = merge16(en2, d, s, LIVE2);
                OFS_GROUP3:   next_en3 = merge16(en3, d, s, LIVE3);
                OFS_GROUP4:   next_en4 = merge16(en4, d, s, LIVE4);
                OFS_SEEN_CLR: begin
                    // set wins: a new event this cycle stays recorded
                    if (s[0]) begin
                        next_seen = (seen & ~d[2:0]) |
                            {|req_all[47:32], |req_all[31:16],
                             |req_all[15:0]};
                    end
                end
                OFS_SEEN_EN: begin
                    if (s[0]) next_seen_en = d[2:0];
                end
                OFS_PEND, OFS_SEEN: begin
                    // read-only, write ignored
                end
                default: next_bresp = RESP_SLVERR;  // unmapped
            endcase
        end
        next_irq = |(next_seen & next_seen_en);
        // ready follows next hold state, so it equals the old comb term
        next_aw_rdy = !next_aw_hold && !next_bvalid;
        next_w_rdy  = !next_w_hold && !next_bvalid;
    end

    // read path: one cycle to rvalid, held until rready
    always_comb begin
        next_rvalid = rvalid && !s_axi_rready_i;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (s_axi_araddr_i & 6'h3C)
                OFS_GROUP2:  next_rdata = {16'h0000, en2};
                OFS_GROUP3:  next_rdata = {16'h0000, en3};
                OFS_GROUP4:  next_rdata = {16'h0000, en4};
                OFS_PEND:    next_rdata = {29'h0000000,
                    |flag_group4_i, |flag_group3_i, |flag_group2_i};
                OFS_SEEN:    next_rdata = {29'h0000000, seen};
                OFS_SEEN_EN: next_rdata = {29'h0000000, seen_en};
                OFS_SEEN_CLR: next_rdata = 32'h00000000; // write-only
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_ar_rdy = !next_rvalid;  // free again once the answer is taken
    end

    // state registers; enables clear at reset so all requests start off
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            en2     <= ENABLE_RESET;
            en3     <= ENABLE_RESET;
            en4     <= ENABLE_RESET;
            seen    <= 3'h0;
            seen_en <= 3'h0;
            irq     <= 1'b0;
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 6'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
            aw_rdy  <= 1'b1;
            w_rdy   <= 1'b1;
            ar_rdy  <= 1'b1;
        end else begin
            en2     <= next_en2;
            en3     <= next_en3;
            en4     <= next_en4;
            seen    <= next_seen;
            seen_en <= next_seen_en;
            irq     <= next_irq;
            aw_hold <= next_aw_hold;
            w_hold  <= next_w_hold;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
            aw_rdy  <= next_aw_rdy;
            w_rdy   <= next_w_rdy;
            ar_rdy  <= next_ar_rdy;
        end
    end

    // bit positions follow the register layout one to one:
    // group2 14 dma4, 13 parallel, 4 dma3, 3 can ev, 2 can rx, 1/0 serial2
    // group3 14 calendar, 13 dma5, 12 codec ev, 11 codec err
    // group4 15/14 dac, 6 can tx, 5 dma7, 4 dma6, 3 crc, 2/1 uart err
    pieb_gate #(
        .WIDTH (NUM_REQ)
    ) u_gate (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .flag_i   ({flag_group4_i, flag_group3_i, flag_group2_i}),
        .enable_i ({en4, en3, en2}),
        .req_o    (req_all)
    );

    assign req_group2_o    = req_all[15:0];
    assign req_group3_o    = req_all[31:16];
    assign req_group4_o    = req_all[47:32];
    assign irq_o           = irq;
    assign s_axi_awready_o = aw_rdy;
    assign s_axi_wready_o  = w_rdy;
    assign s_axi_bvalid_o  = bvalid;
    assign s_axi_bresp_o   = bresp;
    assign s_axi_arready_o = ar_rdy;
    assign s_axi_rvalid_o  = rvalid;
    assign s_axi_rdata_o   = rdata;
    assign s_axi_rresp_o   = rresp;

    chk_unimpl_zero: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ((en3 & ~MASK_GROUP3) == 16'h0000) &&
        ((en2 & ~MASK_GROUP2) == 16'h0000) &&
        ((en4 & ~MASK_GROUP4) == 16'h0000))
        else $error("unimplemented enable bit set");
    chk_can_off: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !HAS_CAN |-> ((req_group2_o & CAN_GROUP2) == 16'h0000 &&
                      (req_group4_o & CAN_GROUP4) == 16'h0000))
        else $error("can request passed on variant without can");
    chk_dac_off: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !HAS_DAC |-> ((req_group4_o & DAC_GROUP4) == 16'h0000))
        else $error("dac request passed on variant without dac");
    chk_reset_clear: assert property (
        @(posedge clk_i)
        $past(!rstn_i) |-> (en2 == 16'h0000 && en3 == 16'h0000 &&
                            en4 == 16'h0000))
        else $error("enables not cleared by reset");
    chk_write_grp3: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (do_write && (aw_take ? s_axi_awaddr_i : aw_addr) == OFS_GROUP3
         && (w_take ? s_axi_wstrb_i[1] : w_strb[1]))
        |=> en3[14:11] == $past(w_take ? s_axi_wdata_i[14:11]
                                        : w_data[14:11]))
        else $error("group3 enable write lost");
    chk_dma4_block: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !en2[14] |=> !req_group2_o[14])
        else $error("dma4 request passed while disabled");
    chk_dac_pass: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (en4[15] && flag_group4_i[15]) |=> req_group4_o[15])
        else $error("dac left request blocked while enabled");
    chk_irq_level: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (|(seen & seen_en)) |-> irq_o)
        else $error("interrupt low with enabled status set");
    chk_read_back: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (ar_take && s_axi_araddr_i == OFS_GROUP2)
        |=> s_axi_rvalid_o && s_axi_rdata_o == {16'h0000, $past(en2)})
        else $error("group2 read data wrong");
endmodule

// *** verif/pieb_src_model.sv ***
// peripheral flag source model feeding the enable bank
`timescale 1ns/1ps
module pieb_src_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        load_i,     // take a new flag pattern
    input  wire logic [47:0] pattern_i,  // group4 : group3 : group2
    output logic      [15:0] flag_group2_o,
    output logic      [15:0] flag_group3_o,
    output logic      [15:0] flag_group4_o
);
    logic [47:0] flags;  // raised requests of all sources
    // flags move only on a load or a reset: masking never touches a source
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flags <= 48'h0;
        end else if (load_i) begin
            flags <= pattern_i;
        end
    end
    assign flag_group2_o = flags[15:0];
    assign flag_group3_o = flags[31:16];
    assign flag_group4_o = flags[47:32];
endmodule

// *** verif/pieb_top_tb.sv ***
// self-checking bench for the enable bank, full and reduced variant
`timescale 1ns/1ps
module pieb_top_tb import pieb_pkg::*;;
    logic        clk_i   = 1'b0;
    logic        rstn_i  = 1'b0;
    logic [5:0]  awaddr  = 6'h00;
    logic [5:0]  araddr  = 6'h00;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'hF;          // byte lanes of the write
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        load    = 1'b0;          // flag model load strobe
    logic [47:0] pattern = 48'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rdata_b;          // full and reduced variant
    logic [15:0] fl2, fl3, fl4;
    logic [47:0] req_all, reqb_all;       // group4 : group3 : group2
    int          err_count  = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    logic [5:0]  ofs [3] = '{OFS_GROUP2, OFS_GROUP3, OFS_GROUP4};
    logic [15:0] em  [3] = '{16'h601F, 16'h7800, 16'hC07E};
    logic [15:0] eb  [3] = '{16'h6013, 16'h7800, 16'h003E};

    always #2.5 clk_i = ~clk_i;

    pieb_src_model pieb_src_model_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .load_i(load), .pattern_i(pattern),
        .flag_group2_o(fl2), .flag_group3_o(fl3), .flag_group4_o(fl4));

    pieb_top pieb_top_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .flag_group2_i(fl2), .flag_group3_i(fl3), .flag_group4_i(fl4),
        .req_group2_o(req_all[15:0]), .req_group3_o(req_all[31:16]),
        .req_group4_o(req_all[47:32]), .irq_o(irq));

    // variant without can and dac, run in lockstep on the same bus
    pieb_top #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) pieb_top_inst_b (
        .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(),
        .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(), .s_axi_rdata_o(rdata_b), .s_axi_rresp_o(),
        .s_axi_rvalid_o(), .s_axi_rready_i(rready),
        .flag_group2_i(fl2), .flag_group3_i(fl3), .flag_group4_i(fl4),
        .req_group2_o(reqb_all[15:0]), .req_group3_o(reqb_all[31:16]),
        .req_group4_o(reqb_all[47:32]), .irq_o());

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard stops at 5000 cycles; whole run needs well under that
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // axi4-lite write; address and data offered together
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge clk_i);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                n = 99;
            end
        end
        if (n != 99) begin
            chk("write answer", 32'h1, 32'h0);
        end
        @(posedge clk_i);  // keeps strobes from toggling twice a step
    endtask

    // axi4-lite read; returns both variants' data
    task automatic rd(input logic [5:0] a, output logic [31:0] d,
                      output logic [31:0] db, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h3;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge clk_i);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                db = rdata_b;
                r = rresp;
                rready <= 1'b0;
                n = 99;
            end
        end
        if (n != 99) begin
            chk("read answer", 32'h1, 32'h0);
        end
        @(posedge clk_i);
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] db;
        logic [1:0]  r;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk("ready idle", 32'h7, {29'h0, awready, wready, arready});
        // reset values, then writable and reserved bits
        for (int g = 0; g < 3; g++) begin
            rd(ofs[g], d, db, r);
            chk("reset value", 32'h0, d);
            wr(ofs[g], 32'hFFFF_FFFF, r);
            rd(ofs[g], d, db, r);
            chk("readback", {16'h0, em[g]}, d);
            chk("readback reduced", {16'h0, eb[g]}, db);
            chk("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
            wr(ofs[g], 32'h0, r);
        end
        // high byte lane only: the low byte must keep its zeros
        wstrb <= 4'h2;
        wr(OFS_GROUP2, 32'hFFFF_FFFF, r);
        wstrb <= 4'hF;
        rd(OFS_GROUP2, d, db, r);
        chk("lane write", {16'h0, em[0] & 16'hFF00}, d);
        chk("lane reduced", {16'h0, eb[0] & 16'hFF00}, db);
        wr(OFS_GROUP2, 32'h0, r);
        $display("test registers done");
        // every request raised; walk one enable bit at a time
        load <= 1'b1;
        pattern <= 48'hFFFF_FFFF_FFFF;
        @(posedge clk_i);
        load <= 1'b0;
        for (int g = 0; g < 3; g++) begin
            for (int i = 0; i < 16; i++) begin
                wr(ofs[g], 32'h1 << i, r);
                repeat (2) @(posedge clk_i);
                d = {16'h0, em[g] & (16'h0001 << i)};
                chk("req", d, {16'h0, req_all[g*16 +: 16]});
                d = {16'h0, eb[g] & (16'h0001 << i)};
                chk("req reduced", d, {16'h0, reqb_all[g*16 +: 16]});
            end
            wr(ofs[g], 32'h0, r);
        end
        $display("test gating done");
        // summary interrupt: raise, mask at the request, clear, re-raise
        wr(OFS_SEEN_CLR, 32'h7, r);
        wr(OFS_SEEN_EN, 32'h7, r);
        chk("irq idle", 32'h0, {31'h0, irq});
        wr(OFS_GROUP2, 32'hFFFF, r);
        repeat (3) @(posedge clk_i);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(OFS_GROUP2, 32'h0, r);
        repeat (2) @(posedge clk_i);
        chk("req masked", 32'h0, {16'h0, req_all[15:0]});
        rd(OFS_PEND, d, db, r);
        chk("flags kept", 32'h7, d);
        wr(OFS_SEEN_CLR, 32'h7, r);
        rd(OFS_SEEN, d, db, r);
        chk("status cleared", 32'h0, d);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(OFS_GROUP2, 32'hFFFF, r);
        repeat (2) @(posedge clk_i);
        chk("req again", 32'h601F, {16'h0, req_all[15:0]});
        wr(OFS_SEEN_EN, 32'h0, r);
        repeat (3) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(OFS_SEEN, d, db, r);
        chk("status sticky", 32'h1, d);
        $display("test interrupt done");
        // unmapped place answers with an error and zero data
        rd(6'h1C, d, db, r);
        chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
        wr(6'h1C, 32'hFFFF, r);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
